// ### include/led_ctrl_map.vh
`ifndef LED_CTRL_MAP_VH
`define LED_CTRL_MAP_VH

// register bus geometry (word addresses)
`define ADDR_W 4
`define DATA_W 32
`define CTRL_WORDS 9
`define CTRL_W 288
// main control register words 0..8, word 8 holds bits 287..256
`define ADDR_CTRL_FIRST 4'h0
`define ADDR_CTRL_LAST 4'h8
`define ADDR_STATUS 4'h9

// field positions in the 288-bit control register
`define CMD_MSB 287
`define CMD_LSB 276
`define CMD_W 12
// command field position inside the top word
`define CMD_WORD_MSB 31
`define CMD_WORD_LSB 20
`define LED_FAULT_MASK_BIT 204
`define SLEW_RATE_BIT 203
`define OPEN_THRESH_BIT 202
`define SHORT_THRESH_BIT 201
`define NEIGHBOUR_CURRENT_BIT 200
`define DOT_CORR_W 168
`define DOT_FIELD_W 7

// reset value: only the led fault mask is set
`define CTRL_RESET_VAL {{83{1'b0}}, 1'b1, {204{1'b0}}}

// command codes
`define CMD_GLOBAL_RESET 12'h25c
`define CMD_SELF_TEST 12'h535
`define CMD_NEIGHBOUR_CHECK 12'h53a
`define CMD_NEGATE_TOGGLE 12'h55a
`define CMD_READ_STATUS 12'h5a3
`define CMD_READ_CONTROL 12'h5ac
`define CMD_READ_GRAYSCALE 12'h5af
`define CMD_ERROR_CLEAR 12'ha53

// readback selects
`define RB_STATUS 2'h0
`define RB_CONTROL 2'h1
`define RB_GRAYSCALE 2'h2
`define RB_RESET_VAL 2'h1

// status word fields
`define ST_RB_LSB 0
`define ST_NEGATE_CHECK_BIT 2
`define ST_LAST_CMD_LSB 4

`endif

// ### core/led_cmd_config.v
`include "led_ctrl_map.vh"

module led_cmd_config (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // register port
    input wire [3:0] addr,
    input wire [31:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    output wire [31:0] rd_data,
    // configuration to the analog and detect logic
    output wire led_fault_mask,
    output wire slew_rate_slow,
    output wire open_led_threshold_select,
    output wire shorted_led_threshold_select,
    output wire neighbour_short_test_current,
    output wire [167:0] dot_correction,
    // command strobes and state
    output wire global_reset_pulse,
    output wire open_short_detector_test_pulse,
    output wire neighbour_pin_short_check_pulse,
    output wire error_clear_pulse,
    output wire negate_check_bit,
    output wire [1:0] readback_select
);

    // command actions, one-hot
    localparam [7:0] ACT_NONE = 8'h00;
    localparam [7:0] ACT_RESET = 8'h01;
    localparam [7:0] ACT_TEST = 8'h02;
    localparam [7:0] ACT_NEIGH = 8'h04;
    localparam [7:0] ACT_NEG = 8'h08;
    localparam [7:0] ACT_RB_ST = 8'h10;
    localparam [7:0] ACT_RB_CTL = 8'h20;
    localparam [7:0] ACT_RB_GS = 8'h40;
    localparam [7:0] ACT_CLEAR = 8'h80;

    reg rst_meta_q;
    reg rst_sync_q;
    wire rst_int_n;

    reg [`CTRL_W-1:0] ctrl_q;
    reg [`CTRL_W-1:0] ctrl_d;
    reg [31:0] rd_data_q;
    reg [31:0] rd_data_d;
    reg global_reset_q;
    reg self_test_q;
    reg neighbour_q;
    reg error_clear_q;
    reg negate_q;
    reg negate_d;
    reg [1:0] rb_sel_q;
    reg [1:0] rb_sel_d;
    reg [`CMD_W-1:0] last_cmd_q;
    reg [`CMD_W-1:0] last_cmd_d;

    wire ctrl_hit;
    wire cmd_write;
    wire [`CMD_W-1:0] cmd_code;
    wire [7:0] action;
    wire [31:0] status_word;

    // map a command code to its action
    function [7:0] decode_cmd;
        input [`CMD_W-1:0] code;
        begin
            case (code)
                `CMD_GLOBAL_RESET: decode_cmd = ACT_RESET;
                `CMD_ERROR_CLEAR: decode_cmd = ACT_CLEAR;
                `CMD_SELF_TEST: decode_cmd = ACT_TEST;
                `CMD_NEIGHBOUR_CHECK: decode_cmd = ACT_NEIGH;
                `CMD_NEGATE_TOGGLE: decode_cmd = ACT_NEG;
                `CMD_READ_STATUS: decode_cmd = ACT_RB_ST;
                `CMD_READ_CONTROL: decode_cmd = ACT_RB_CTL;
                `CMD_READ_GRAYSCALE: decode_cmd = ACT_RB_GS;
                default: decode_cmd = ACT_NONE;
            endcase
        end
    endfunction

    // pick one 32-bit word out of the control register
    function [31:0] ctrl_word;
        input [`CTRL_W-1:0] value;
        input [3:0] idx;
        begin
            ctrl_word = value[idx*32 +: 32];
        end
    endfunction

    // reset release through two flip-flops
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_int_n = rst_sync_q;

    // address decode and command capture
    assign ctrl_hit = (addr <= `ADDR_CTRL_LAST);
    // the command runs when the top word is written
    assign cmd_write = wr_en && (addr == `ADDR_CTRL_LAST);
    assign cmd_code = wr_data[`CMD_WORD_MSB:`CMD_WORD_LSB];
    assign action = cmd_write ? decode_cmd(cmd_code) : ACT_NONE;

    // status word shows readback select, negate bit, last command
    assign status_word = {16'h0000, last_cmd_q, 1'b0, negate_q, rb_sel_q};

    // next state of the control register
    always @* begin
        ctrl_d = ctrl_q;
        // plain store of any written word, command or not
        if (wr_en && ctrl_hit) begin
            ctrl_d[addr*32 +: 32] = wr_data;
        end
        // global reset puts every field back to its default
        if (action == ACT_RESET) begin
            ctrl_d = `CTRL_RESET_VAL;
        end
    end

    // negate check bit: toggled by its code, cleared by reset
    always @* begin
        case (action)
            ACT_NEG: begin
                negate_d = ~negate_q;
            end
            ACT_RESET: begin
                negate_d = 1'b0;
            end
            default: begin
                negate_d = negate_q;
            end
        endcase
    end

    // readback select follows the three read codes
    always @* begin
        case (action)
            ACT_RB_ST: begin
                rb_sel_d = `RB_STATUS;
            end
            ACT_RB_CTL: begin
                rb_sel_d = `RB_CONTROL;
            end
            ACT_RB_GS: begin
                rb_sel_d = `RB_GRAYSCALE;
            end
            ACT_RESET: begin
                rb_sel_d = `RB_RESET_VAL;
            end
            default: begin
                rb_sel_d = rb_sel_q;
            end
        endcase
    end

    // last command code written to the top word
    always @* begin
        last_cmd_d = last_cmd_q;
        if (cmd_write) begin
            last_cmd_d = cmd_code;
        end
    end

    // control register store
    always @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            // fault mask set, all other fields clear
            ctrl_q <= `CTRL_RESET_VAL;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // negate check bit store
    always @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            negate_q <= 1'b0;
        end else begin
            negate_q <= negate_d;
        end
    end

    // readback select store, control register after reset
    always @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            rb_sel_q <= `RB_RESET_VAL;
        end else begin
            rb_sel_q <= rb_sel_d;
        end
    end

    // last command store, shown in the status word
    always @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            last_cmd_q <= 12'h000;
        end else begin
            last_cmd_q <= last_cmd_d;
        end
    end

    // global reset strobe, one cycle
    always @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            global_reset_q <= 1'b0;
        end else begin
            global_reset_q <= (action == ACT_RESET);
        end
    end

    // detector self-test strobe, one cycle
    always @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            self_test_q <= 1'b0;
        end else begin
            self_test_q <= (action == ACT_TEST);
        end
    end

    // neighbour pin check strobe, one cycle
    always @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            neighbour_q <= 1'b0;
        end else begin
            neighbour_q <= (action == ACT_NEIGH);
        end
    end

    // error clear strobe, one cycle
    always @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            error_clear_q <= 1'b0;
        end else begin
            error_clear_q <= (action == ACT_CLEAR);
        end
    end

    // read data, valid the cycle after the read strobe
    always @* begin
        rd_data_d = 32'h00000000;
        if (rd_en) begin
            case (addr)
                4'h0: begin
                    rd_data_d = ctrl_word(ctrl_q, 4'h0);
                end
                4'h1: begin
                    rd_data_d = ctrl_word(ctrl_q, 4'h1);
                end
                4'h2: begin
                    rd_data_d = ctrl_word(ctrl_q, 4'h2);
                end
                4'h3: begin
                    rd_data_d = ctrl_word(ctrl_q, 4'h3);
                end
                4'h4: begin
                    rd_data_d = ctrl_word(ctrl_q, 4'h4);
                end
                4'h5: begin
                    rd_data_d = ctrl_word(ctrl_q, 4'h5);
                end
                4'h6: begin
                    rd_data_d = ctrl_word(ctrl_q, 4'h6);
                end
                4'h7: begin
                    rd_data_d = ctrl_word(ctrl_q, 4'h7);
                end
                4'h8: begin
                    // command word, field stays readable
                    rd_data_d = ctrl_word(ctrl_q, 4'h8);
                end
                `ADDR_STATUS: begin
                    rd_data_d = status_word;
                end
                default: begin
                    // unmapped words read as zero
                    rd_data_d = 32'h00000000;
                end
            endcase
        end
    end

    always @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            rd_data_q <= 32'h00000000;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    // outputs, all taken from flip-flops
    assign rd_data = rd_data_q;

    // analog and detector configuration bits
    assign led_fault_mask = ctrl_q[`LED_FAULT_MASK_BIT];
    assign slew_rate_slow = ctrl_q[`SLEW_RATE_BIT];
    assign open_led_threshold_select = ctrl_q[`OPEN_THRESH_BIT];
    assign shorted_led_threshold_select =
        ctrl_q[`SHORT_THRESH_BIT];
    assign neighbour_short_test_current =
        ctrl_q[`NEIGHBOUR_CURRENT_BIT];
    // red, green, blue per channel, 7 bits each from bit 0
    assign dot_correction = ctrl_q[`DOT_CORR_W-1:0];

    // command strobes, one cycle each
    assign global_reset_pulse = global_reset_q;
    assign open_short_detector_test_pulse = self_test_q;
    assign neighbour_pin_short_check_pulse = neighbour_q;
    assign error_clear_pulse = error_clear_q;

    // command levels, held until a command that changes them
    assign negate_check_bit = negate_q;
    assign readback_select = rb_sel_q;

endmodule // led_cmd_config

// ### verif/led_cmd_checker.sv
module led_cmd_checker (
    // clock, reset and write side of the bus
    input wire clk_sys,
    input wire rst_n,
    input wire [3:0] addr,
    input wire [31:0] wr_data,
    input wire wr_en,
    // outputs under watch
    input wire led_fault_mask,
    input wire slew_rate_slow,
    input wire [167:0] dot_correction,
    input wire global_reset_pulse,
    input wire open_short_detector_test_pulse,
    input wire neighbour_pin_short_check_pulse,
    input wire error_clear_pulse,
    input wire negate_check_bit,
    input wire [1:0] readback_select
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // command write and config word write
    sequence s_cmd(logic [11:0] c);
        wr_en && addr == 4'h8 && wr_data[31:20] == c;
    endsequence
    sequence s_cfg;
        wr_en && addr == 4'h6;
    endsequence
    property p_grst;
        s_cmd(12'h25c) |=> global_reset_pulse && led_fault_mask
            && readback_select == 2'h1 && dot_correction == 168'h0;
    endproperty
    a_grst: assert property (p_grst) else $error("global reset");
    property p_eclr;
        s_cmd(12'ha53) |=> error_clear_pulse;
    endproperty
    a_eclr: assert property (p_eclr) else $error("error clear");
    property p_test;
        s_cmd(12'h535) |=> open_short_detector_test_pulse;
    endproperty
    a_test: assert property (p_test) else $error("self test");
    property p_aps;
        s_cmd(12'h53a) |=> neighbour_pin_short_check_pulse;
    endproperty
    a_aps: assert property (p_aps) else $error("pin check");
    property p_neg;
        s_cmd(12'h55a) |=> negate_check_bit != $past(negate_check_bit);
    endproperty
    a_neg: assert property (p_neg) else $error("negate");
    property p_rdst;
        s_cmd(12'h5a3) |=> readback_select == 2'h0;
    endproperty
    a_rdst: assert property (p_rdst) else $error("status sel");
    property p_rdgs;
        s_cmd(12'h5af) |=> readback_select == 2'h2;
    endproperty
    a_rdgs: assert property (p_rdgs) else $error("gray sel");
    property p_cfg;
        s_cfg |=> led_fault_mask == $past(wr_data[12])
            && slew_rate_slow == $past(wr_data[11]);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config");
    property p_dc;
        wr_en && addr == 4'h0 |=> dot_correction[31:0] == $past(wr_data);
    endproperty
    a_dc: assert property (p_dc) else $error("dot corr");
endmodule // led_cmd_checker

bind led_cmd_config led_cmd_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .led_fault_mask(led_fault_mask), .slew_rate_slow(slew_rate_slow),
    .dot_correction(dot_correction), .global_reset_pulse(global_reset_pulse),
    .open_short_detector_test_pulse(open_short_detector_test_pulse),
    .neighbour_pin_short_check_pulse(neighbour_pin_short_check_pulse),
    .error_clear_pulse(error_clear_pulse),
    .negate_check_bit(negate_check_bit), .readback_select(readback_select));

// ### verif/host_bus.sv
module host_bus (
    // clock and read return
    input wire clk_sys,
    input wire [31:0] rd_data,
    // request side
    output logic [3:0] addr = 4'h0,
    output logic [31:0] wr_data = 32'h0,
    output logic wr_en = 1'b0,
    output logic rd_en = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // one-cycle write, command code in the top word
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
        #1;
    endtask
    // one-cycle read, data taken in the following cycle
    task rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask
endmodule // host_bus

// ### verif/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr;
    logic [31:0] wr_data, rd_data, d;
    logic wr_en, rd_en, mask, slew, opn, shrt, cur, gr, st, neighbour_pin_short_check, clr, neg;
    logic [167:0] dc;
    logic [1:0] rb;
    int errors = 0;
    int checks_done = 0;
    // code, pulses {reset,test,pin,clear}, readback, negate
    logic [18:0] rows [9] = '{{12'h5a3, 7'h00}, {12'h55a, 7'h01},
        {12'h535, 7'h21}, {12'h53a, 7'h11}, {12'ha53, 7'h09},
        {12'h5af, 7'h05}, {12'h5ac, 7'h03}, {12'h55a, 7'h02},
        {12'h25c, 7'h42}};
    host_bus host (.clk_sys(clk_sys), .rd_data(rd_data), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en));
    led_cmd_config dut (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .led_fault_mask(mask), .slew_rate_slow(slew),
        .open_led_threshold_select(opn),
        .shorted_led_threshold_select(shrt),
        .neighbour_short_test_current(cur), .dot_correction(dc),
        .global_reset_pulse(gr), .open_short_detector_test_pulse(st),
        .neighbour_pin_short_check_pulse(neighbour_pin_short_check), .error_clear_pulse(clr),
        .negate_check_bit(neg), .readback_select(rb));
    // clock
    initial forever #4 clk_sys = ~clk_sys;
    // compare and count
    task chk(input string n, input logic [167:0] e, input logic [167:0] s);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // verdict
    task end_of_test;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("cfg", 5'h10, {mask, slew, opn, shrt, cur});
        chk("dc", 0, dc);
        for (int i = 0; i < 9; i++) begin
            host.wr(4'h8, {rows[i][18:7], 20'h0});
            chk("cmd", rows[i][6:0], {gr, st, neighbour_pin_short_check, clr, rb, neg});
        end
        host.wr(4'h6, 32'h0000_0f00);
        chk("cfg", 5'h0f, {mask, slew, opn, shrt, cur});
        host.rd(4'h6, d);
        chk("word6", 32'h0000_0f00, d);
        host.wr(4'h0, {11'h0, 7'h11, 7'h0a, 7'h05});
        chk("dc", {7'h11, 7'h0a, 7'h05}, dc[20:0]);
        host.wr(4'h8, 32'h7770_0000);
        chk("unknown", 7'h02, {gr, st, neighbour_pin_short_check, clr, rb, neg});
        host.rd(4'h8, d);
        chk("word8", 32'h7770_0000, d);
        host.rd(4'hc, d);
        chk("unmapped", 0, d);
        host.wr(4'h8, 32'h25c0_0000);
        chk("cfg", 5'h10, {mask, slew, opn, shrt, cur});
        chk("dc", 0, dc);
        end_of_test;
    end
    // watchdog
    initial begin
        repeat (1000) @(posedge clk_sys);
        errors++;
        end_of_test;
    end
endmodule // testbench
